// >>> serial_flash_host_interface.sv
`timescale 1ns/1ps
module serial_flash_host_interface import flash_if_pkg::*; #(
	parameter int RECOV_LONG_CYC = recov_long_cyc,
	parameter int RECOV_SHORT_CYC = recov_short_cyc
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_spi_sclk,
	input wire logic i_spi_cs_n,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe,
	input wire logic i_quad_enable_bit,
	input wire logic i_hold_is_reset,
	input wire logic i_busy,
	input wire logic i_busy_long,
	input wire logic [7:0] i_rd_data,
	output logic [23:0] o_rd_addr,
	output cmd_t o_cmd,
	output logic o_cmd_valid,
	output logic o_abort,
	output logic o_four_line_command_mode,
	output logic o_blocked
);

	// ****************************************
	// declarations
	// ****************************************
	logic link_rst;
	logic [3:0] lvl_l;
	logic qe_l;
	logic hrs_l;
	logic fl_l;
	logic busy_l;
	logic hold_en;

	link_state_t st_q, st_d;
	logic [4:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [23:0] adr_q, adr_d;
	logic [2:0] bits_q, bits_d;
	cmd_info_t info_q, info_d;
	logic [2:0] w_in;
	cmd_info_t dec;

	logic [7:0] fr_code_q, fr_code_d;
	logic [23:0] fr_addr_q, fr_addr_d;
	logic fr_done_q, fr_done_d;
	logic fr_ctrl_q, fr_ctrl_d;
	logic fr_aligned_q, fr_aligned_d;
	logic start_tgl_q, start_tgl_d;

	logic [7:0] osh_q, osh_d;
	logic [3:0] ocnt_q, ocnt_d;
	logic [3:0] io_q, io_d;
	logic [3:0] oe_q, oe_d;
	logic held_q, held_d;
	logic byte_tgl_q, byte_tgl_d;
	logic [7:0] cur;

	logic [3:0] sy;
	logic sy_cs;
	logic sy_io3;
	logic sy_start;
	logic sy_byte;
	logic cs_prev_q, cs_prev_d;
	logic start_prev_q, start_prev_d;
	logic byte_prev_q, byte_prev_d;
	logic fl_q, fl_d;
	logic arm_q, arm_d;
	logic blk_q, blk_d;
	logic met_q, met_d;
	logic abort_q, abort_d;
	logic cmd_valid_q, cmd_valid_d;
	cmd_t cmd_q, cmd_d;
	logic [23:0] rd_addr_q, rd_addr_d;
	logic [7:0] rd_word_q, rd_word_d;
	logic cs_rise;
	logic pin_low;
	logic rl_run;
	logic rec_run;
	logic exec;
	logic sw_rst;
	logic [timer_w-1:0] rec_val;

	// shift a narrow group of lines into a register
	function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] io, input logic [2:0] w);
		case (w)
			3'h4: return {v[19:0], io};
			3'h2: return {v[21:0], io[1:0]};
			default: return {v[22:0], io[0]};
		endcase
	endfunction

	// ****************************************
	// link domain: levels from the system side
	// ****************************************
	// chip select high, system reset or a blocking reset clears the frame
	assign link_rst = i_spi_cs_n | i_reset | blk_q;

	sync_bit #(.W(4), .RST_VAL(4'h0)) u_link_sync (
		.i_clk(i_spi_sclk),
		.i_reset(i_reset),
		.i_clk_en(1'b1),
		.i_d({i_quad_enable_bit, i_hold_is_reset, fl_q, i_busy}),
		.o_q(lvl_l)
	);
	assign qe_l = lvl_l[3];
	assign hrs_l = lvl_l[2];
	assign fl_l = lvl_l[1];
	assign busy_l = lvl_l[0];
	// hold only in plain hold configuration, never in quad operation
	assign hold_en = !qe_l && !hrs_l && !fl_l;

	// ****************************************
	// link domain: input side, rising edge
	// ****************************************
	// width of the current input phase
	always_comb begin
		if (st_q == st_cmd) begin
			w_in = fl_l ? 3'h4 : 3'h1;
		end else begin
			w_in = info_q.addr_w;
		end
	end

	assign dec = decode_cmd(8'(shift_in({16'h0000, sh_q}, i_io, w_in)), qe_l, fl_l, busy_l);

	// frame sequencing and frame record
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		adr_d = adr_q;
		bits_d = bits_q;
		info_d = info_q;
		fr_code_d = fr_code_q;
		fr_addr_d = fr_addr_q;
		fr_done_d = fr_done_q;
		fr_ctrl_d = fr_ctrl_q;
		fr_aligned_d = fr_aligned_q;
		start_tgl_d = start_tgl_q;
		if (!held_q && st_q != st_ignore) begin
			bits_d = bits_q + w_in;
			fr_aligned_d = (bits_d == 3'h0);
			case (st_q)
				st_cmd: begin
					if (cnt_q == 5'h00) begin
						fr_done_d = 1'b0;
						fr_ctrl_d = 1'b0;
					end
					cnt_d = cnt_q + 5'(w_in);
					sh_d = 8'(shift_in({16'h0000, sh_q}, i_io, w_in));
					if (cnt_d == cmd_bits) begin
						cnt_d = 5'h00;
						info_d = dec;
						fr_code_d = sh_d;
						fr_done_d = 1'b1;
						if (!dec.valid) begin
							st_d = st_ignore;
						end else if (dec.has_addr) begin
							st_d = st_addr;
						end else if (dec.rd) begin
							st_d = st_data;
							start_tgl_d = !start_tgl_q;
						end else begin
							st_d = st_ctrl;
							fr_ctrl_d = 1'b1;
						end
					end
				end
				st_addr: begin
					cnt_d = cnt_q + 5'(w_in);
					adr_d = shift_in(adr_q, i_io, w_in);
					if (cnt_d == addr_bits) begin
						cnt_d = 5'h00;
						fr_addr_d = adr_d;
						if (!info_q.rd) begin
							st_d = st_ctrl;
							fr_ctrl_d = 1'b1;
						end else if (info_q.dummy != 4'h0) begin
							st_d = st_dummy;
						end else begin
							st_d = st_data;
							start_tgl_d = !start_tgl_q;
						end
					end
				end
				st_dummy: begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_d == {1'b0, info_q.dummy}) begin
						st_d = st_data;
						start_tgl_d = !start_tgl_q;
					end
				end
				default: begin
					st_d = st_q; // data out or control tail, until chip select rises
				end
			endcase
		end
	end

	// frame state, cleared at every chip select rise
	always_ff @(posedge i_spi_sclk or posedge link_rst) begin
		if (link_rst) begin
			st_q <= st_cmd;
			cnt_q <= 5'h00;
			sh_q <= 8'h00;
			adr_q <= 24'h000000;
			bits_q <= 3'h0;
			info_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			adr_q <= adr_d;
			bits_q <= bits_d;
			info_q <= info_d;
		end
	end

	// frame record survives chip select for the system side
	always_ff @(posedge i_spi_sclk or posedge i_reset) begin
		if (i_reset) begin
			fr_code_q <= 8'h00;
			fr_addr_q <= 24'h000000;
			fr_done_q <= 1'b0;
			fr_ctrl_q <= 1'b0;
			fr_aligned_q <= 1'b0;
			start_tgl_q <= 1'b0;
		end else begin
			fr_code_q <= fr_code_d;
			fr_addr_q <= fr_addr_d;
			fr_done_q <= fr_done_d;
			fr_ctrl_q <= fr_ctrl_d;
			fr_aligned_q <= fr_aligned_d;
			start_tgl_q <= start_tgl_d;
		end
	end

	// ****************************************
	// link domain: output side, falling edge
	// ****************************************
	always_comb begin
		osh_d = osh_q;
		ocnt_d = ocnt_q;
		io_d = io_q;
		oe_d = 4'h0;
		byte_tgl_d = byte_tgl_q;
		cur = (ocnt_q == 4'h0) ? rd_word_q : (osh_q << info_q.data_w);
		// hold latches only on a low clock
		held_d = hold_en && !i_io[3];
		if (st_q == st_data && !held_d) begin
			osh_d = cur;
			ocnt_d = ((ocnt_q == 4'h0) ? byte_bits : ocnt_q) - 4'(info_q.data_w);
			if (ocnt_q == 4'h0) begin
				byte_tgl_d = !byte_tgl_q;
			end
			case (info_q.data_w)
				3'h4: begin
					io_d = cur[7:4];
					oe_d = 4'hF;
				end
				3'h2: begin
					io_d = {2'b00, cur[7:6]};
					oe_d = 4'h3;
				end
				default: begin
					io_d = {2'b00, cur[7], 1'b0};
					oe_d = 4'h2;
				end
			endcase
		end
	end

	// outputs launch on the falling clock edge
	always_ff @(negedge i_spi_sclk or posedge link_rst) begin
		if (link_rst) begin
			osh_q <= 8'h00;
			ocnt_q <= 4'h0;
			io_q <= 4'h0;
			oe_q <= 4'h0;
			held_q <= 1'b0;
		end else begin
			osh_q <= osh_d;
			ocnt_q <= ocnt_d;
			io_q <= io_d;
			oe_q <= oe_d;
			held_q <= held_d;
		end
	end

	always_ff @(negedge i_spi_sclk or posedge i_reset) begin
		if (i_reset) begin
			byte_tgl_q <= 1'b0;
		end else begin
			byte_tgl_q <= byte_tgl_d;
		end
	end

	assign o_io = io_q;
	assign o_io_oe = oe_q;

	// ****************************************
	// system domain
	// ****************************************
	sync_bit #(.W(4), .RST_VAL(sync_rst_val)) u_sys_sync (
		.i_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_clk_en(i_clk_en),
		.i_d({byte_tgl_q, start_tgl_q, i_io[3], i_spi_cs_n}),
		.o_q(sy)
	);
	assign sy_cs = sy[0];
	assign sy_io3 = sy[1];
	assign sy_start = sy[2];
	assign sy_byte = sy[3];

	// reset pin only when selected and quad lines are off
	assign pin_low = !i_quad_enable_bit && i_hold_is_reset && !sy_io3;
	assign cs_rise = sy_cs && !cs_prev_q;
	// control commands run only on a byte-aligned chip select rise
	assign exec = cs_rise && fr_done_q && fr_ctrl_q && fr_aligned_q && !blk_q && !pin_low;
	assign sw_rst = exec && fr_code_q == reset_cmd && arm_q;
	assign rec_val = i_busy_long ? timer_w'(RECOV_LONG_CYC) : timer_w'(RECOV_SHORT_CYC);

	down_timer #(.W(timer_w)) u_low_timer (
		.i_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_clk_en(i_clk_en),
		.i_load(!pin_low),
		.i_value(timer_w'(reset_low_cyc)),
		.o_run(rl_run)
	);

	down_timer #(.W(timer_w)) u_recov_timer (
		.i_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_clk_en(i_clk_en),
		.i_load(sw_rst),
		.i_value(rec_val),
		.o_run(rec_run)
	);

	// mode, reset sequencing and command hand-off
	always_comb begin
		cs_prev_d = sy_cs;
		start_prev_d = sy_start;
		byte_prev_d = sy_byte;
		fl_d = fl_q;
		arm_d = arm_q;
		cmd_d = cmd_q;
		cmd_valid_d = 1'b0;
		abort_d = 1'b0;
		rd_addr_d = rd_addr_q;
		rd_word_d = i_rd_data;
		met_d = pin_low && (met_q || !rl_run);
		blk_d = pin_low || rec_run || sw_rst;
		if (sy_byte != byte_prev_q) begin
			rd_addr_d = rd_addr_q + 24'h000001;
		end
		if (sy_start != start_prev_q && !blk_q) begin
			cmd_d = '{code: fr_code_q, addr: fr_addr_q, is_read: 1'b1};
			cmd_valid_d = 1'b1;
			rd_addr_d = fr_addr_q;
			arm_d = 1'b0;
		end
		if (exec) begin
			cmd_d = '{code: fr_code_q, addr: erase_align(fr_code_q, fr_addr_q), is_read: 1'b0};
			cmd_valid_d = 1'b1;
			arm_d = (fr_code_q == reset_arm_cmd);
			if (fr_code_q == four_line_enter_cmd && i_quad_enable_bit) begin
				fl_d = 1'b1;
			end else if (fr_code_q == four_line_exit_cmd) begin
				fl_d = 1'b0;
			end
		end
		if (pin_low && !rl_run && !met_q) begin
			abort_d = 1'b1;
		end
		if (sw_rst || (!pin_low && met_q)) begin
			fl_d = 1'b0;
			arm_d = 1'b0;
			abort_d = abort_d || sw_rst;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			cs_prev_q <= 1'b1;
			start_prev_q <= 1'b0;
			byte_prev_q <= 1'b0;
			fl_q <= 1'b0;
			arm_q <= 1'b0;
			blk_q <= 1'b0;
			met_q <= 1'b0;
			abort_q <= 1'b0;
			cmd_valid_q <= 1'b0;
			cmd_q <= '0;
			rd_addr_q <= 24'h000000;
			rd_word_q <= 8'h00;
		end else if (i_clk_en) begin
			cs_prev_q <= cs_prev_d;
			start_prev_q <= start_prev_d;
			byte_prev_q <= byte_prev_d;
			fl_q <= fl_d;
			arm_q <= arm_d;
			blk_q <= blk_d;
			met_q <= met_d;
			abort_q <= abort_d;
			cmd_valid_q <= cmd_valid_d;
			cmd_q <= cmd_d;
			rd_addr_q <= rd_addr_d;
			rd_word_q <= rd_word_d;
		end
	end

	assign o_rd_addr = rd_addr_q;
	assign o_cmd = cmd_q;
	assign o_cmd_valid = cmd_valid_q;
	assign o_abort = abort_q;
	assign o_four_line_command_mode = fl_q;
	assign o_blocked = blk_q;
endmodule

// >>> flash_if_pkg.sv
package flash_if_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int sys_clk_period_ns = 10;
	localparam int reset_low_pulse_time_ns = 1000;
	localparam int reset_low_cyc = (reset_low_pulse_time_ns + sys_clk_period_ns - 1) / sys_clk_period_ns;
	localparam int recov_long_ms = 12;
	localparam int recov_long_cyc = (recov_long_ms * 1000000) / sys_clk_period_ns;
	localparam int recov_short_cyc = 3000;
	localparam int timer_w = 21;

	// ****************************************
	// array geometry and framing
	// ****************************************
	localparam int page_bytes = 256;
	localparam int sector_bytes = 16 * page_bytes;
	localparam int block32_bytes = 8 * sector_bytes;
	localparam int block64_bytes = 16 * sector_bytes;
	localparam logic [23:0] sector_mask = ~24'(sector_bytes - 1);
	localparam logic [23:0] block32_mask = ~24'(block32_bytes - 1);
	localparam logic [23:0] block64_mask = ~24'(block64_bytes - 1);
	localparam logic [4:0] addr_bits = 5'h18;
	localparam logic [4:0] cmd_bits = 5'h08;
	localparam logic [3:0] byte_bits = 4'h8;
	localparam logic [3:0] dummy_fast = 4'h8;
	localparam logic [3:0] dummy_dual_io = 4'h4;
	localparam logic [3:0] dummy_quad_io = 4'h6;
	localparam logic [3:0] sync_rst_val = 4'h3;

	// ****************************************
	// command codes
	// ****************************************
	localparam logic [7:0] read_cmd = 8'h03;
	localparam logic [7:0] fast_read_cmd = 8'h0B;
	localparam logic [7:0] dual_output_read_cmd = 8'h3B;
	localparam logic [7:0] dual_io_read_cmd = 8'hBB;
	localparam logic [7:0] quad_output_read_cmd = 8'h6B;
	localparam logic [7:0] quad_io_read_cmd = 8'hEB;
	localparam logic [7:0] status_read_cmd = 8'h05;
	localparam logic [7:0] status1_read_cmd = 8'h35;
	localparam logic [7:0] config_read_cmd = 8'h15;
	localparam logic [7:0] ident_read_cmd = 8'h9F;
	localparam logic [7:0] write_enable_cmd = 8'h06;
	localparam logic [7:0] write_disable_cmd = 8'h04;
	localparam logic [7:0] status_write_cmd = 8'h01;
	localparam logic [7:0] status1_write_cmd = 8'h31;
	localparam logic [7:0] config_write_cmd = 8'h11;
	localparam logic [7:0] sector_erase_cmd = 8'h20;
	localparam logic [7:0] block32_erase_cmd = 8'h52;
	localparam logic [7:0] block64_erase_cmd = 8'hD8;
	localparam logic [7:0] chip_erase_cmd = 8'h60;
	localparam logic [7:0] chip_erase2_cmd = 8'hC7;
	localparam logic [7:0] page_program_cmd = 8'h02;
	localparam logic [7:0] quad_program_cmd = 8'h32;
	localparam logic [7:0] suspend_cmd = 8'h75;
	localparam logic [7:0] resume_cmd = 8'h7A;
	localparam logic [7:0] power_down_cmd = 8'hB9;
	localparam logic [7:0] reset_arm_cmd = 8'h66;
	localparam logic [7:0] reset_cmd = 8'h99;
	localparam logic [7:0] four_line_enter_cmd = 8'h38;
	localparam logic [7:0] four_line_exit_cmd = 8'hFF;

	typedef enum logic [2:0] {
		st_cmd = 3'b000,
		st_addr = 3'b001,
		st_dummy = 3'b010,
		st_data = 3'b011,
		st_ctrl = 3'b100,
		st_ignore = 3'b101
	} link_state_t;

	typedef struct packed {
		logic valid;
		logic rd;
		logic has_addr;
		logic [2:0] addr_w;
		logic [3:0] dummy;
		logic [2:0] data_w;
	} cmd_info_t;

	typedef struct packed {
		logic [7:0] code;
		logic [23:0] addr;
		logic is_read;
	} cmd_t;

	// classify a command code for the current mode
	function automatic cmd_info_t decode_cmd(input logic [7:0] c, input logic qe, input logic fl,
		input logic busy);
		cmd_info_t r;
		r = '0;
		r.addr_w = fl ? 3'h4 : 3'h1;
		r.data_w = r.addr_w;
		case (c)
			read_cmd, fast_read_cmd: begin
				r.valid = !busy;
				r.rd = 1'b1;
				r.has_addr = 1'b1;
				r.dummy = (c == fast_read_cmd) ? dummy_fast : 4'h0;
			end
			dual_output_read_cmd, dual_io_read_cmd: begin
				r.valid = !busy && !fl;
				r.rd = 1'b1;
				r.has_addr = 1'b1;
				r.data_w = 3'h2;
				r.addr_w = (c == dual_io_read_cmd) ? 3'h2 : 3'h1;
				r.dummy = (c == dual_io_read_cmd) ? dummy_dual_io : dummy_fast;
			end
			quad_output_read_cmd, quad_io_read_cmd: begin
				r.valid = !busy && qe && !(fl && c == quad_output_read_cmd);
				r.rd = 1'b1;
				r.has_addr = 1'b1;
				r.data_w = 3'h4;
				r.addr_w = (c == quad_io_read_cmd) ? 3'h4 : 3'h1;
				r.dummy = (c == quad_io_read_cmd) ? dummy_quad_io : dummy_fast;
			end
			status_read_cmd, status1_read_cmd, config_read_cmd, ident_read_cmd: begin
				r.valid = 1'b1;
				r.rd = 1'b1;
			end
			write_enable_cmd, write_disable_cmd, status_write_cmd, status1_write_cmd, config_write_cmd,
			suspend_cmd, resume_cmd, power_down_cmd, reset_arm_cmd, reset_cmd: begin
				r.valid = 1'b1;
			end
			chip_erase_cmd, chip_erase2_cmd: begin
				r.valid = !busy;
			end
			sector_erase_cmd, block32_erase_cmd, block64_erase_cmd, page_program_cmd, quad_program_cmd: begin
				r.valid = !busy;
				r.has_addr = 1'b1;
			end
			four_line_enter_cmd: begin
				r.valid = qe && !fl;
			end
			four_line_exit_cmd: begin
				r.valid = fl;
			end
			default: begin
				r.valid = 1'b0;
			end
		endcase
		return r;
	endfunction

	// align erase addresses to their granule
	function automatic logic [23:0] erase_align(input logic [7:0] c, input logic [23:0] a);
		case (c)
			sector_erase_cmd: return a & sector_mask;
			block32_erase_cmd: return a & block32_mask;
			block64_erase_cmd: return a & block64_mask;
			chip_erase_cmd, chip_erase2_cmd: return 24'h000000;
			default: return a;
		endcase
	endfunction

endpackage

// >>> sync_bit.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of independent levels
module sync_bit #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	// first stage is read only by the second
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_q <= RST_VAL;
			o_q <= RST_VAL;
		end else if (i_clk_en) begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule

// >>> down_timer.sv
`timescale 1ns/1ps
// loadable down counter, running while non-zero
module down_timer #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_load,
	input wire logic [W-1:0] i_value,
	output logic o_run
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// next count
	always_comb begin
		cnt_d = cnt_q;
		if (i_load) begin
			cnt_d = i_value;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_q <= '0;
		end else if (i_clk_en) begin
			cnt_q <= cnt_d;
		end
	end

	assign o_run = (cnt_q != '0);
endmodule

// >>> flash_if_chk.sv
`timescale 1ns/1ps
// ****************
// port checks of the flash interface
// ****************
module flash_if_chk import flash_if_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_spi_cs_n,
	input wire logic i_busy,
	input wire logic i_quad_enable_bit,
	input wire logic [3:0] o_io_oe,
	input wire cmd_t o_cmd,
	input wire logic o_cmd_valid,
	input wire logic o_abort,
	input wire logic o_four_line_command_mode,
	input wire logic o_blocked
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	a_valid_one_pulse: assert property (o_cmd_valid |=> !o_cmd_valid) else $error("accept too long");
	a_abort_one_pulse: assert property (o_abort |=> !o_abort) else $error("abort too long");
	a_blocked_no_cmd: assert property (o_blocked && $past(o_blocked) |-> !o_cmd_valid) else $error("taken while blocked");
	a_idle_no_drive: assert property (i_spi_cs_n |-> o_io_oe == 4'h0) else $error("drive while idle");
	a_quad_needs_qe: assert property (|o_io_oe[3:2] |-> i_quad_enable_bit) else $error("quad without enable");
	a_mode_needs_qe: assert property ($rose(o_four_line_command_mode) |-> i_quad_enable_bit) else $error("mode without enable");
	a_sector_align: assert property (o_cmd_valid && o_cmd.code == sector_erase_cmd
		|-> o_cmd.addr[11:0] == 12'h000) else $error("sector unaligned");
	a_block_align: assert property (o_cmd_valid && o_cmd.code == block64_erase_cmd
		|-> o_cmd.addr[15:0] == 16'h0000) else $error("block unaligned");
	a_busy_no_read: assert property (o_cmd_valid && o_cmd.code == read_cmd |-> !i_busy) else $error("read while busy");
	a_abort_blocks: assert property (o_abort |-> ##[0:2] o_blocked) else $error("abort not blocking");
endmodule
bind serial_flash_host_interface flash_if_chk flash_if_chk_i (.*);

// >>> spi_host_model.sv
`timescale 1ns/1ps
// ****************
// host controller, mode 0, clock still between frames except when tick2 pulses it with chip select high
// ****************
module spi_host_model (
	output logic o_sclk,
	output logic o_cs_n,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe,
	input wire logic [3:0] i_io
);
	logic [3:0] q;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'hF;
		o_io_oe = 4'hD;
	end
	// data set while low, sampled at rise, device launches at fall
	task beat(input logic [3:0] d, input logic [3:0] oe);
		o_io = d;
		o_io_oe = oe;
		#40 o_sclk = 1'b1;
		q = i_io;
		#40 o_sclk = 1'b0;
	endtask
	task start();
		o_cs_n = 1'b0;
		#40;
	endtask
	// release after whole beats only, then idle
	task stop();
		#40 o_cs_n = 1'b1;
		o_io = 4'hF;
		o_io_oe = 4'hD;
		#120;
	endtask
	// msb first over w lines
	task send(input logic [7:0] b, input int w);
		logic [3:0] d;
		for (int i = 0; i < 8 / w; i++) begin
			d = 4'hF;
			for (int j = 0; j < w; j++) begin
				d[w - 1 - j] = b[7 - i * w - j];
			end
			beat(d, (w == 1) ? 4'hD : 4'hF);
		end
	endtask
	task recv(input int w, output logic [7:0] r);
		for (int i = 0; i < 8 / w; i++) begin
			beat(4'hF, (w == 4) ? 4'h0 : (w == 2) ? 4'hC : 4'hD);
			for (int j = 0; j < w; j++) begin
				r[7 - i * w - j] = (w == 1) ? q[1] : q[w - 1 - j];
			end
		end
	endtask
	// two edges with chip select high let mode changes settle
	task tick2();
		repeat (2) beat(4'hF, 4'hD);
		#120;
	endtask
	task pin3(input logic v);
		o_io[3] = v;
	endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin fails++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
	import flash_if_pkg::*;
	logic i_sys_clk, i_reset, i_busy, i_busy_long, i_quad_enable_bit, i_hold_is_reset;
	logic oe_seen;
	logic [7:0] i_rd_data, r;
	wire logic sclk, cs_n, o_cmd_valid, o_abort, o_four_line_command_mode, o_blocked;
	wire logic [3:0] h_io, h_oe, o_io, o_io_oe, io;
	wire logic [23:0] o_rd_addr;
	wire cmd_t o_cmd;
	cmd_t last_cmd;
	int fails, n_checks, n_valid, n_abort, n0, a0;
	logic [7:0] ec [3] = '{sector_erase_cmd, block32_erase_cmd, block64_erase_cmd};
	logic [23:0] ea [3] = '{24'h123000, 24'h120000, 24'h120000};
	logic [7:0] rc [3] = '{read_cmd, dual_output_read_cmd, quad_output_read_cmd};
	logic [1:0] pm [4] = '{2'b10, 2'b10, 2'b11, 2'b00};
	int pl [4] = '{150, 50, 150, 150};
	// line level: device, else host, else pull-up
	assign io = (o_io_oe & o_io) | (~o_io_oe & h_oe & h_io) | (~o_io_oe & ~h_oe);
	serial_flash_host_interface #(.RECOV_LONG_CYC(50), .RECOV_SHORT_CYC(20)) serial_flash_host_interface_i (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(1'b1), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
		.i_io(io), .o_io(o_io), .o_io_oe(o_io_oe), .i_quad_enable_bit(i_quad_enable_bit),
		.i_hold_is_reset(i_hold_is_reset), .i_busy(i_busy), .i_busy_long(i_busy_long), .i_rd_data(i_rd_data),
		.o_rd_addr(o_rd_addr), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid), .o_abort(o_abort),
		.o_four_line_command_mode(o_four_line_command_mode), .o_blocked(o_blocked));
	spi_host_model spi_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io), .o_io_oe(h_oe), .i_io(io));
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	// count pulses, note any drive
	always @(posedge i_sys_clk) begin
		if (o_cmd_valid === 1'b1) begin
			n_valid++;
			last_cmd = o_cmd;
		end
		if (o_abort === 1'b1) n_abort++;
		if (o_io_oe !== 4'h0) oe_seen = 1'b1;
	end
	task finish_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task set_in(input logic qe, input logic b, input logic hr);
		@(posedge i_sys_clk);
		#1 i_quad_enable_bit = qe;
		i_busy = b;
		i_hold_is_reset = hr;
	endtask
	task got(input int n, input string m);
		`CHK(n_valid - n0, n, m)
		n0 = n_valid;
	endtask
	task frame(input logic [7:0] c, input int w, input int na, input logic [23:0] a, input int nd, input int rw);
		spi_host_model_i.start();
		spi_host_model_i.send(c, w);
		for (int i = 0; i < na; i++) begin
			spi_host_model_i.send(a[23 - 8 * i -: 8], w);
		end
		repeat (nd) spi_host_model_i.send(8'hFF, w);
		if (rw > 0) spi_host_model_i.recv(rw, r);
		spi_host_model_i.stop();
	endtask
	initial begin
		#1000000;
		fails++;
		$display("wrong value at %0t: timeout", $time);
		finish_test();
	end
	initial begin
		i_reset = 1'b1;
		i_busy_long = 1'b0;
		i_rd_data = 8'hC6;
		set_in(1'b0, 1'b0, 1'b0);
		repeat (4) @(posedge i_sys_clk);
		#1 i_reset = 1'b0;
		spi_host_model_i.tick2();
		`CHK(o_four_line_command_mode, 1'b0, "mode after reset")
		frame(write_enable_cmd, 1, 0, 0, 0, 0);
		got(1, "write enable");
		`CHK(last_cmd.code, write_enable_cmd, "code")
		spi_host_model_i.start();
		spi_host_model_i.send(write_enable_cmd, 1);
		spi_host_model_i.beat(4'hF, 4'hD);
		spi_host_model_i.stop();
		got(0, "partial frame");
		for (int i = 0; i < 3; i++) begin
			frame(ec[i], 1, 3, 24'h123456, 0, 0);
			got(1, "erase");
			`CHK(last_cmd.addr, ea[i], "erase address")
		end
		oe_seen = 1'b0;
		frame(8'hA5, 1, 3, 24'h000000, 0, 1);
		got(0, "invalid code");
		`CHK(oe_seen, 1'b0, "drive after invalid code")
		frame(quad_output_read_cmd, 1, 3, 24'h000000, 1, 4);
		frame(four_line_enter_cmd, 1, 0, 0, 0, 0);
		got(0, "quad without enable");
		tend_line("commands");
		set_in(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			frame(rc[i], 1, 3, 24'h000100, (i > 0) ? 1 : 0, 1 << i);
			got(1, "read");
			`CHK(r, 8'hC6, "read data")
			`CHK(last_cmd.addr, 24'h000100, "read address")
			`CHK(last_cmd.is_read, 1'b1, "read flag")
			`CHK(o_rd_addr, 24'h000102, "next address")
		end
		tend_line("reads");
		set_in(1'b1, 1'b1, 1'b0);
		frame(read_cmd, 1, 3, 24'h000000, 0, 1);
		got(0, "read while busy");
		set_in(1'b1, 1'b0, 1'b0);
		frame(four_line_enter_cmd, 1, 0, 0, 0, 0);
		spi_host_model_i.tick2();
		`CHK(o_four_line_command_mode, 1'b1, "mode entry")
		n0 = n_valid;
		frame(write_enable_cmd, 4, 0, 0, 0, 0);
		got(1, "four-line command");
		frame(four_line_exit_cmd, 4, 0, 0, 0, 0);
		spi_host_model_i.tick2();
		`CHK(o_four_line_command_mode, 1'b0, "mode exit")
		frame(four_line_enter_cmd, 1, 0, 0, 0, 0);
		spi_host_model_i.tick2();
		for (int i = 0; i < 2; i++) begin
			@(posedge i_sys_clk);
			#1 i_busy_long = i[0];
			a0 = n_abort;
			frame(reset_arm_cmd, 4 - 3 * i, 0, 0, 0, 0);
			frame(reset_cmd, 4 - 3 * i, 0, 0, 0, 0);
			`CHK(n_abort - a0, 1, "software reset")
			`CHK(o_blocked, 1'b1, "recovery")
			`CHK(o_four_line_command_mode, 1'b0, "mode after reset")
			repeat (20) @(posedge i_sys_clk);
			#1 `CHK(o_blocked, i[0], "recovery length")
			repeat (40) @(posedge i_sys_clk);
			#1 `CHK(o_blocked, 1'b0, "recovery end")
			#1 spi_host_model_i.tick2();
		end
		a0 = n_abort;
		frame(reset_arm_cmd, 1, 0, 0, 0, 0);
		frame(write_enable_cmd, 1, 0, 0, 0, 0);
		frame(reset_cmd, 1, 0, 0, 0, 0);
		`CHK(n_abort - a0, 0, "reset not adjacent")
		tend_line("resets");
		for (int i = 0; i < 4; i++) begin
			set_in(pm[i][0], 1'b0, pm[i][1]);
			a0 = n_abort;
			spi_host_model_i.pin3(1'b0);
			repeat (pl[i]) @(posedge i_sys_clk);
			#1 `CHK(o_blocked, (i < 2), "pin block")
			spi_host_model_i.pin3(1'b1);
			repeat (10) @(posedge i_sys_clk);
			`CHK(n_abort - a0, (i == 0) ? 1 : 0, "pin abort")
		end
		tend_line("reset pin");
		// hold during data out: line 3 low with the clock low
		spi_host_model_i.tick2();
		spi_host_model_i.start();
		spi_host_model_i.send(read_cmd, 1);
		repeat (3) spi_host_model_i.send(8'h00, 1);
		#20 `CHK(o_io_oe, 4'h2, "single drive")
		spi_host_model_i.pin3(1'b0);
		spi_host_model_i.beat(4'h7, 4'hD);
		#1 `CHK(o_io_oe, 4'h0, "output during hold")
		spi_host_model_i.stop();
		tend_line("hold");
		finish_test();
	end
	task tend_line(input string s);
		$display("test %s done", s);
	endtask
endmodule
